// *** hw/power_clock_pkg.sv ***
// Constants for the power and timing control register block.
// Assumes one system clock; all pins are synchronised inside the block.
package power_clock_pkg;

    // ========================================================
    // Register map
    localparam logic [6:0] REG_POWER_AND_TIMING_ADDR = 7'h15;
    localparam logic [7:0] REG_POWER_AND_TIMING_RST  = 8'h00;

    // ========================================================
    // Field positions
    localparam int CLOCK_SEL_HI  = 7;
    localparam int CLOCK_SEL_LO  = 6;
    localparam int CLK_DIV_HI    = 5;
    localparam int CLK_DIV_LO    = 4;
    localparam int POWER_DOWN_BIT = 3;
    localparam int RAW_MOD_BIT   = 2;
    localparam int POWER_LVL_HI  = 1;
    localparam int POWER_LVL_LO  = 0;

    // ========================================================
    // Encodings
    localparam logic [7:0] POWER_DOWN_CMD  = 8'h08;
    localparam logic [1:0] CLK_SRC_CMOS    = 2'h0;
    localparam logic [1:0] CLK_SRC_CRYSTAL = 2'h1;
    localparam logic [1:0] CLK_SRC_LVDS    = 2'h2;
    localparam logic [1:0] CLK_SRC_RC      = 2'h3;
    localparam logic [1:0] DIV_BY_16       = 2'h0;
    localparam logic [1:0] DIV_BY_8        = 2'h1;
    localparam logic [1:0] DIV_BY_4        = 2'h2;
    localparam logic [1:0] DIV_BY_2        = 2'h3;
    localparam logic [1:0] PWR_LOW         = 2'h0;
    localparam logic [1:0] PWR_UNDEFINED   = 2'h1;
    localparam logic [1:0] PWR_MEDIAN      = 2'h2;
    localparam logic [1:0] PWR_FAST        = 2'h3;

    // ========================================================
    // Serial frame layout and resume word
    localparam logic [4:0]  FRAME_BITS   = 5'h10;
    localparam logic [4:0]  HEADER_BITS  = 5'h08;
    localparam int          RW_BIT       = 15;
    localparam logic [15:0] RESUME_WORD  = 16'hFFFF;

    // ========================================================
    // Modulator clock half periods, minus one, in system clocks
    localparam logic [2:0] HALF_LAST_16 = 3'h7;
    localparam logic [2:0] HALF_LAST_8  = 3'h3;
    localparam logic [2:0] HALF_LAST_4  = 3'h1;
    localparam logic [2:0] HALF_LAST_2  = 3'h0;

endpackage

// *** hw/mod_clock_divider.sv ***
// Modulator clock divider: master clock divided by 16, 8, 4 or 2.
// Assumes the ratio select comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module mod_clock_divider
(
    input  wire logic       clk_sys,   // Master clock
    input  wire logic       nrst,      // Sync reset, low active
    input  wire logic       enable,    // Low while powered down
    input  wire logic [1:0] ratioSel,  // Divide ratio code
    output logic            modClk     // Divided clock, from flop
);

    typedef struct packed
    {
        logic [2:0] cnt;
        logic       modClk;
    } div_state_t;

    div_state_t q;
    div_state_t next_q;
    logic [2:0] halfLast;

    // ========================================================
    // Half period lookup
    always_comb
    begin
        unique case (ratioSel)
            power_clock_pkg::DIV_BY_16: halfLast = power_clock_pkg::HALF_LAST_16;
            power_clock_pkg::DIV_BY_8:  halfLast = power_clock_pkg::HALF_LAST_8;
            power_clock_pkg::DIV_BY_4:  halfLast = power_clock_pkg::HALF_LAST_4;
            power_clock_pkg::DIV_BY_2:  halfLast = power_clock_pkg::HALF_LAST_2;
        endcase
    end

    // Toggle every half period, stopped when disabled
    always_comb
    begin
        next_q = q;
        if (!enable)
        begin
            next_q.cnt    = 3'h0;
            next_q.modClk = 1'b0;
        end
        else if (q.cnt >= halfLast)
        begin
            next_q.cnt    = 3'h0;
            next_q.modClk = ~q.modClk;
        end
        else
        begin
            next_q.cnt = q.cnt + 3'h1;
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign modClk = q.modClk;

endmodule

`default_nettype wire

// *** hw/power_clock_mode_control.sv ***
// Power and timing control register with its serial slave port.
// Assumes serial pins are asynchronous and much slower than clk_sys.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - The register sits at address 0x15, resets to 0x00, and its fields read back.
// - Bits 7:6 choose CMOS, crystal, LVDS or internal RC as the clock source.
// - Bits 5:4 divide the master clock by 16, 8, 4 or 2 for the modulator clock.
// - A write that sets bit 3 with any other bit is dropped entirely.
// - In power-down all blocks stop and normal serial frames are not serviced; here only the modulator clock stops, the serial receiver keeps running.
// - Power-down ends only by reset pin, serial resume word or power cycle.
// - Bit 2 enables raw modulator output, forces low power, and freezes the level field.
// - Bits 1:0 choose low, median or fast core power.
module power_clock_mode_control
(
    input  wire logic       clk_sys,               // Master clock, 25 MHz
    input  wire logic       nrst,                  // Sync reset, power cycle
    input  wire logic       resetPinN,             // Hardware reset pin
    input  wire logic       spiSclk,               // Serial clock pin
    input  wire logic       spiCsN,                // Chip select pin
    input  wire logic       spiSdi,                // Serial data in pin
    output logic            spiSdo,                // Serial data out
    output logic            spiSdoEn,              // Data out drive enable
    output logic [1:0]      clockSource,           // Selected clock source
    output logic [1:0]      clockDivSel,           // Modulator divide code
    output logic            modulatorFrequencyClk, // Divided modulator clock
    output logic            rawModulatorOutEnable, // Raw modulator output on
    output logic [1:0]      corePowerLevel,        // Effective core power
    output logic            poweredDown            // Device in power-down
);

    typedef struct packed
    {
        logic [1:0]  sclkSync;
        logic [1:0]  csSync;
        logic [1:0]  sdiSync;
        logic [1:0]  rstPinSync;
        logic        sclkPrev;
        logic        csPrev;
        logic [4:0]  bitCnt;
        logic [15:0] rxShift;
        logic [7:0]  txShift;
        logic        sdo;
        logic        sdoEn;
        logic [1:0]  clockSel;
        logic [1:0]  clkDiv;
        logic        rawMod;
        logic [1:0]  powerLevel;
        logic        powerDown;
        logic [1:0]  effPower;
    } ctrl_state_t;

    ctrl_state_t q;
    ctrl_state_t next_q;

    logic        sclkRise;
    logic        sclkFall;
    logic        csActive;
    logic        frameEnd;
    logic [7:0]  readValue;
    logic [7:0]  wrData;
    logic [6:0]  hdrAddr;
    logic        hdrRead;
    logic        writeHit;
    logic        pdMixed;

    // ========================================================
    // Edge and frame detection on synchronised pins
    assign sclkRise = q.sclkSync[1] & ~q.sclkPrev;
    assign sclkFall = ~q.sclkSync[1] & q.sclkPrev;
    assign csActive = ~q.csSync[1];
    assign frameEnd = q.csSync[1] & ~q.csPrev;

    // Header fields as the eighth bit arrives
    assign hdrRead = q.rxShift[6];
    assign hdrAddr = {q.rxShift[5:0], q.sdiSync[1]};

    // Write frame decode
    assign wrData   = q.rxShift[7:0];
    assign writeHit = (q.bitCnt == power_clock_pkg::FRAME_BITS)
                      && !q.rxShift[power_clock_pkg::RW_BIT]
                      && (q.rxShift[14:8] == power_clock_pkg::REG_POWER_AND_TIMING_ADDR);
    assign pdMixed  = wrData[power_clock_pkg::POWER_DOWN_BIT]
                      && (wrData != power_clock_pkg::POWER_DOWN_CMD);

    // Read-back image of the register
    assign readValue = {q.clockSel, q.clkDiv, q.powerDown,
                        q.rawMod, q.powerLevel};

    // ========================================================
    // Next state
    always_comb
    begin
        next_q = q;

        // Two-stage synchronisers
        next_q.sclkSync   = {q.sclkSync[0], spiSclk};
        next_q.csSync     = {q.csSync[0], spiCsN};
        next_q.sdiSync    = {q.sdiSync[0], spiSdi};
        next_q.rstPinSync = {q.rstPinSync[0], resetPinN};
        next_q.sclkPrev   = q.sclkSync[1];
        next_q.csPrev     = q.csSync[1];

        // Serial shift in, mode 0, sampled on rising clock
        if (!csActive)
        begin
            next_q.bitCnt = 5'h00;
        end
        else if (sclkRise && (q.bitCnt < power_clock_pkg::FRAME_BITS))
        begin
            next_q.rxShift = {q.rxShift[14:0], q.sdiSync[1]};
            next_q.bitCnt  = q.bitCnt + 5'h01;
            if (q.bitCnt == (power_clock_pkg::HEADER_BITS - 5'h01))
            begin
                if (hdrRead && (hdrAddr == power_clock_pkg::REG_POWER_AND_TIMING_ADDR))
                begin
                    next_q.txShift = readValue;
                end
                else
                begin
                    next_q.txShift = 8'h00;
                end
            end
        end

        // Shift out on falling clock during the data byte
        if (csActive && sclkFall && !q.powerDown
            && (q.bitCnt >= power_clock_pkg::HEADER_BITS))
        begin
            next_q.sdo     = q.txShift[7];
            next_q.txShift = {q.txShift[6:0], 1'b0};
        end

        // Frame completion
        if (frameEnd)
        begin
            if (q.powerDown)
            begin
                // Only the resume word is recognised here
                if ((q.bitCnt == power_clock_pkg::FRAME_BITS)
                    && (q.rxShift == power_clock_pkg::RESUME_WORD))
                begin
                    next_q.powerDown = 1'b0;
                end
            end
            else if (writeHit && !pdMixed)
            begin
                // Accepted write stores all fields, the level only when bit 2 is clear; exactly 0x08 also powers down
                next_q.powerDown = wrData[power_clock_pkg::POWER_DOWN_BIT];
                next_q.clockSel  = wrData[power_clock_pkg::CLOCK_SEL_HI:
                                          power_clock_pkg::CLOCK_SEL_LO];
                next_q.clkDiv    = wrData[power_clock_pkg::CLK_DIV_HI:
                                          power_clock_pkg::CLK_DIV_LO];
                next_q.rawMod    = wrData[power_clock_pkg::RAW_MOD_BIT];
                if (!wrData[power_clock_pkg::RAW_MOD_BIT])
                begin
                    next_q.powerLevel = wrData[power_clock_pkg::POWER_LVL_HI:
                                               power_clock_pkg::POWER_LVL_LO];
                end
            end
        end

        // Hardware reset pin clears the register and leaves power-down
        if (!q.rstPinSync[1])
        begin
            next_q.clockSel   = 2'h0;
            next_q.clkDiv     = 2'h0;
            next_q.rawMod     = 1'b0;
            next_q.powerLevel = 2'h0;
            next_q.powerDown  = 1'b0;
        end

        // Serial output only serviced while powered
        next_q.sdoEn = csActive && !q.powerDown;
        if (!next_q.sdoEn)
        begin
            next_q.sdo = 1'b0;
        end

        // Effective core power level
        if (next_q.rawMod || (next_q.powerLevel == power_clock_pkg::PWR_UNDEFINED))
        begin
            next_q.effPower = power_clock_pkg::PWR_LOW;
        end
        else
        begin
            next_q.effPower = next_q.powerLevel;
        end
    end

    // State register, idle select and reset pin levels at reset
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            q            <= '0;
            q.csSync     <= 2'h3;
            q.csPrev     <= 1'b1;
            q.sclkSync   <= 2'h0;
            q.rstPinSync <= 2'h3;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ========================================================
    // Modulator clock, stopped in power-down
    mod_clock_divider mod_clock_divider_inst
    (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .enable   (!q.powerDown),
        .ratioSel (q.clkDiv),
        .modClk   (modulatorFrequencyClk)
    );

    // Outputs straight from state flops
    assign spiSdo                = q.sdo;
    assign spiSdoEn              = q.sdoEn;
    assign clockSource           = q.clockSel;
    assign clockDivSel           = q.clkDiv;
    assign rawModulatorOutEnable = q.rawMod;
    assign corePowerLevel        = q.effPower;
    assign poweredDown           = q.powerDown;

endmodule

`default_nettype wire

// *** bench/power_clock_checker.sv ***
// Port-level assertions for the power and timing control block.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none

module power_clock_checker
(
    input wire logic       clk_sys,               // Master clock
    input wire logic       nrst,                  // Sync reset, low active
    input wire logic       resetPinN,             // Hardware reset pin
    input wire logic       spiSclk,               // Serial clock pin
    input wire logic       spiCsN,                // Chip select pin
    input wire logic       spiSdi,                // Serial data in pin
    input wire logic       spiSdo,                // Serial data out
    input wire logic       spiSdoEn,              // Data out drive enable
    input wire logic [1:0] clockSource,           // Selected clock source
    input wire logic [1:0] clockDivSel,           // Modulator divide code
    input wire logic       modulatorFrequencyClk, // Divided modulator clock
    input wire logic       rawModulatorOutEnable, // Raw modulator output on
    input wire logic [1:0] corePowerLevel,        // Effective core power
    input wire logic       poweredDown            // Device in power-down
);
    // ========================================================
    // Assertions, all on the master clock
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_reset_clears_all: assert property ($rose(nrst) |-> {clockSource, clockDivSel,
        rawModulatorOutEnable, corePowerLevel, poweredDown} == 8'h00)
        else $error("outputs not cleared by reset");
    a_down_no_drive: assert property (poweredDown [*2] |-> !spiSdoEn)
        else $error("data out driven in power-down");
    a_down_clock_stop: assert property (poweredDown [*2] |-> !modulatorFrequencyClk)
        else $error("modulator clock runs in power-down");
    a_raw_forces_low: assert property (rawModulatorOutEnable |-> corePowerLevel == 2'h0)
        else $error("raw output without low power");
    a_no_undef_level: assert property (corePowerLevel != 2'h1)
        else $error("undefined power level driven");
    a_pin_exits_down: assert property (!resetPinN [*3] |->
        ##[0:4] (!poweredDown && clockSource == 2'h0))
        else $error("reset pin did not clear the register");
    a_div_two_toggle: assert property ($rose(modulatorFrequencyClk) &&
        clockDivSel == 2'h3 && $stable(clockDivSel) |=> !modulatorFrequencyClk)
        else $error("divide by two clock not toggling");
    a_fields_hold_idle: assert property ((spiCsN && resetPinN) [*8] |=>
        $stable({clockSource, clockDivSel, rawModulatorOutEnable, corePowerLevel, poweredDown}))
        else $error("fields changed without an access");
    a_sdo_idle_off: assert property (spiCsN [*6] |-> !spiSdoEn)
        else $error("data out driven while deselected");
endmodule

bind power_clock_mode_control power_clock_checker power_clock_checker_inst
(
    .clk_sys               (clk_sys),
    .nrst                  (nrst),
    .resetPinN             (resetPinN),
    .spiSclk               (spiSclk),
    .spiCsN                (spiCsN),
    .spiSdi                (spiSdi),
    .spiSdo                (spiSdo),
    .spiSdoEn              (spiSdoEn),
    .clockSource           (clockSource),
    .clockDivSel           (clockDivSel),
    .modulatorFrequencyClk (modulatorFrequencyClk),
    .rawModulatorOutEnable (rawModulatorOutEnable),
    .corePowerLevel        (corePowerLevel),
    .poweredDown           (poweredDown)
);

`default_nettype wire

// *** bench/spi_host_model.sv ***
// Host side of the serial port: mode 0, 16-bit frames, MSB first.
// Assumes a frame task is called from the bench at falling clock edges.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
(
    input  wire logic clk_sys,  // Master clock
    input  wire logic spiSdo,   // Data out from device
    input  wire logic spiSdoEn, // Device drive enable
    output logic      spiSclk,  // Serial clock, idle low
    output logic      spiCsN,   // Chip select, low active
    output logic      spiSdi    // Serial data in
);
    logic lineBit; // Data line as seen by the host

    // ========================================================
    // Undriven line wanders: inverse of last level each cycle
    always @(negedge clk_sys)
    begin
        lineBit <= spiSdoEn ? spiSdo : ~lineBit;
    end

    initial
    begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b0;
        lineBit = 1'b0;
    end

    // One frame; low phase 8 clocks, high phase 4
    task automatic xfer(input logic [15:0] word, output logic [7:0] rd, output logic en);
        rd = 8'h00;
        en = 1'b0;
        spiCsN = 1'b0;
        repeat (6) @(negedge clk_sys);
        for (int i = 15; i >= 0; i--)
        begin
            spiSdi = word[i];
            repeat (8) @(negedge clk_sys);
            if (i < 8)
                rd = {rd[6:0], lineBit};
            en = en | spiSdoEn;
            spiSclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            spiSclk = 1'b0;
        end
        repeat (6) @(negedge clk_sys);
        spiCsN = 1'b1;
        spiSdi = ~spiSdi;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

`default_nettype wire

// *** bench/tb_power_clock_mode_control.sv ***
// Self-checking bench for the power and timing control block.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none

module tb_power_clock_mode_control;
    logic       clk_sys, nrst, resetPinN, spiSclk, spiCsN, spiSdi, spiSdo, spiSdoEn;
    logic       modClk, rawEn, poweredDown, en;
    logic [1:0] clockSource, clockDivSel, corePowerLevel;
    logic [7:0] rd, outs, rises;
    int         numErrors, checksDone;

    assign outs = {clockSource, clockDivSel, poweredDown, rawEn, corePowerLevel};

    power_clock_mode_control power_clock_mode_control_inst (.clk_sys(clk_sys), .nrst(nrst),
        .resetPinN(resetPinN), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi),
        .spiSdo(spiSdo), .spiSdoEn(spiSdoEn), .clockSource(clockSource),
        .clockDivSel(clockDivSel), .modulatorFrequencyClk(modClk),
        .rawModulatorOutEnable(rawEn), .corePowerLevel(corePowerLevel),
        .poweredDown(poweredDown));
    spi_host_model spi_host_model_inst (.clk_sys(clk_sys), .spiSdo(spiSdo),
        .spiSdoEn(spiSdoEn), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi));

    // ========================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi_host_model_inst.xfer({1'b0, a, d}, rd, en);
    endtask
    task automatic rdr(input logic [6:0] a);
        spi_host_model_inst.xfer({1'b1, a, 8'h00}, rd, en);
    endtask
    // Rising edges of the modulator clock in 64 master clocks
    task automatic count_rises();
        logic prev;
        rises = 8'h00;
        prev = modClk;
        repeat (64)
        begin
            @(negedge clk_sys);
            if (modClk === 1'b1 && prev === 1'b0)
                rises++;
            prev = modClk;
        end
    endtask
    // Pulse the hardware reset pin low for four clocks, then let it settle
    task automatic pin_reset();
        resetPinN = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetPinN = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic giveVerdict();
        $display("Checks %0d, errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_fields();
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            wr(7'h15, {c, c, 2'h0, c});
            chk(outs, {c, c, 2'h0, (c == 2'h1) ? 2'h0 : c}, "fields out");
            rdr(7'h15);
            chk(rd, {c, c, 2'h0, c}, "readback");
            count_rises();
            chk(rises, 8'h04 << i, "modulator rate");
        end
    endtask
    task automatic t_refused();
        logic [7:0] bad [3] = '{8'h88, 8'h0C, 8'h09};
        wr(7'h16, 8'hC3);
        rdr(7'h16);
        chk(rd, 8'h00, "unmapped read");
        foreach (bad[k])
            wr(7'h15, bad[k]);
        chk(outs, 8'hF3, "guarded write");
        rdr(7'h15);
        chk(rd, 8'hF3, "register kept");
    endtask
    task automatic t_raw();
        wr(7'h15, 8'h04);
        chk(outs, 8'h04, "raw forces low");
        rdr(7'h15);
        chk(rd, 8'h07, "level frozen");
        wr(7'h15, 8'h02);
        chk(outs, 8'h02, "level accepted");
    endtask
    task automatic t_power();
        wr(7'h15, power_clock_pkg::POWER_DOWN_CMD);
        chk(outs, 8'h08, "powered down");
        count_rises();
        chk(rises, 8'h00, "clock stopped");
        rdr(7'h15);
        chk({7'h00, en}, 8'h00, "port silent");
        wr(7'h15, 8'h30);
        spi_host_model_inst.xfer(16'hFFFF, rd, en);
        chk(outs, 8'h00, "resumed");
        rdr(7'h15);
        chk(rd, 8'h00, "down bit clear");
        wr(7'h15, 8'h62);
        chk(outs, 8'h62, "fields before pin");
        pin_reset();
        chk(outs, 8'h00, "pin clears fields");
        wr(7'h15, power_clock_pkg::POWER_DOWN_CMD);
        chk(outs, 8'h08, "down again");
        pin_reset();
        chk(outs, 8'h00, "pin exit");
        wr(7'h15, power_clock_pkg::POWER_DOWN_CMD);
        nrst = 1'b0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(outs, 8'h00, "power cycle exit");
        rdr(7'h15);
        chk(rd, 8'h00, "port back after cycle");
    endtask

    // ========================================================
    // Clock, main sequence and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        numErrors = 0;
        checksDone = 0;
        nrst = 1'b0;
        resetPinN = 1'b1;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(outs, 8'h00, "reset outputs");
        rdr(7'h15);
        chk(rd, power_clock_pkg::REG_POWER_AND_TIMING_RST, "reset value");
        t_fields();
        t_refused();
        t_raw();
        t_power();
        giveVerdict();
    end
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        numErrors++;
        giveVerdict();
    end
endmodule

`default_nettype wire
